// ### inc/nsr_pkg.sv
// ****************************************************************
// shared constants and carriers for the lane slice reset control
// ****************************************************************
package nsr_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam int NSR_ADDR_W = 8;
    localparam int NSR_DATA_W = 16;
    localparam logic [NSR_ADDR_W-1:0] NSR_SLICE_RESET_CONTROL_ADDR = 8'h03;
    localparam logic [NSR_DATA_W-1:0] NSR_SLICE_RESET_CONTROL_RST =
        16'h0000;
    localparam logic [NSR_DATA_W-1:0] NSR_UNMAPPED_READ = 16'h0000;

    // field positions inside slice_reset_control
    localparam int NSR_CLR_GATE_BIT = 0;
    localparam int NSR_LANE_RST_BIT = 1;
    localparam int NSR_TRI_RST_BIT = 2;
    localparam int NSR_CTRL_FIELD_W = 3;

    // ************************************************************
    // least reset hold, counted by the controller in pll cycles
    // on top of one control clock cycle
    // ************************************************************
    localparam int NSR_HOLD_CTRL_CYCLES = 1;
    localparam int NSR_HOLD_PLL_W8 = 72;
    localparam int NSR_HOLD_PLL_W4 = 40;
    localparam int NSR_HOLD_PLL_W2 = 24;

    // default lane count of one slice group
    localparam int NSR_NUM_LANES = 6;

    // register port request from the controller
    typedef struct packed {
        logic [NSR_ADDR_W-1:0] addr;
        logic wr_en;
        logic [NSR_DATA_W-1:0] wr_data;
    } nsr_reg_req_t;

    // mask register contents, owned outside this block
    typedef struct packed {
        logic tristate_reset_mask;
        logic [NSR_NUM_LANES-1:0] lane_reset_mask;
    } nsr_mask_t;

endpackage : nsr_pkg

// ### hw/nsr_strobe_gate.sv
`timescale 1ns/1ps
// ****************************************************************
// strobe path gate, cleared by a toggle of the gate-clear bit
// ****************************************************************
module nsr_strobe_gate
    import nsr_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic clr_gate_bit_i,
    input wire logic gate_set_i,
    output logic gate_o
);

    typedef struct packed {
        logic prev_clr;
        logic gate;
    } nsr_gate_state_t;

    nsr_gate_state_t state;
    nsr_gate_state_t next_state;
    logic toggle;

    // either edge of the bit counts; a level alone does nothing
    assign toggle = clr_gate_bit_i ^ state.prev_clr;

    // a set in the clearing cycle wins so no strobe event is lost
    always_comb begin
        next_state = state;
        next_state.prev_clr = clr_gate_bit_i;
        if (gate_set_i) begin
            next_state.gate = 1'b1;
        end else if (toggle) begin
            next_state.gate = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign gate_o = state.gate;

    // ************************************************************
    // checks
    // ************************************************************
    property p_gate_clear;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (toggle && !gate_set_i) |=> !gate_o;
    endproperty
    a_gate_clear: assert property (p_gate_clear)
        else $error("gate not cleared after clear toggle");

    property p_gate_set_wins;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (!sys_rst_i && gate_set_i) |=> gate_o;
    endproperty
    a_gate_set_wins: assert property (p_gate_set_wins)
        else $error("gate set lost");

    property p_gate_holds;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (!sys_rst_i && gate_o && !toggle) |=> gate_o;
    endproperty
    a_gate_holds: assert property (p_gate_holds)
        else $error("gate dropped without clear toggle");

    c_gate_cleared: cover property (@(posedge core_clk_i)
        disable iff (sys_rst_i) gate_o ##1 !gate_o);

endmodule : nsr_strobe_gate

// ### hw/nsr_slice_reset_ctrl.sv
`timescale 1ns/1ps
module nsr_slice_reset_ctrl
    import nsr_pkg::*;
#(
    parameter int NUM_LANES = NSR_NUM_LANES
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire nsr_reg_req_t reg_req_i,
    input wire nsr_mask_t mask_i,
    input wire logic phy_write_enable_i,
    input wire logic [NUM_LANES-1:0] tx_data_i,
    input wire logic [NUM_LANES-1:0] tx_init_i,
    input wire logic tri_data_i,
    input wire logic tx_init_tri_i,
    input wire logic strobe_gate_set_i,
    output logic [NSR_DATA_W-1:0] reg_rd_data_o,
    output logic [NUM_LANES-1:0] lane_slice_soft_reset_o,
    output logic tristate_slice_soft_reset_o,
    output logic [NUM_LANES-1:0] tx_pad_o,
    output logic tri_pad_o,
    output logic strobe_gate_o,
    output logic wren_violation_o
);

    // ************************************************************
    // elaboration check
    // ************************************************************
    if (NUM_LANES != NSR_NUM_LANES) begin : g_bad_lanes
        $error("lane count must match the mask register width");
    end

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [NSR_CTRL_FIELD_W-1:0] ctrl;
        logic [NUM_LANES-1:0] lane_rst;
        logic tri_rst;
        logic [NUM_LANES-1:0] tx_pad;
        logic tri_pad;
        logic [NSR_DATA_W-1:0] rd_data;
        logic wren_violation;
    } nsr_state_t;

    nsr_state_t state;
    nsr_state_t next_state;
    logic ctrl_hit;
    logic lane_rst_on;
    logic tri_rst_on;

    // the register port decodes only its own offset
    assign ctrl_hit = (reg_req_i.addr == NSR_SLICE_RESET_CONTROL_ADDR);
    assign lane_rst_on = state.ctrl[NSR_LANE_RST_BIT];
    assign tri_rst_on = state.ctrl[NSR_TRI_RST_BIT];

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_state = state;
        // reserved bits are not stored and read back as zero
        if (reg_req_i.wr_en && ctrl_hit) begin
            next_state.ctrl = reg_req_i.wr_data[NSR_CTRL_FIELD_W-1:0];
        end
        // read data follows the address every cycle
        if (ctrl_hit) begin
            next_state.rd_data = {{(NSR_DATA_W-NSR_CTRL_FIELD_W){1'b0}},
                state.ctrl};
        end else begin
            next_state.rd_data = NSR_UNMAPPED_READ;
        end
        // masked lanes run on untouched
        next_state.lane_rst = {NUM_LANES{lane_rst_on}}
            & ~mask_i.lane_reset_mask;
        next_state.tri_rst = tri_rst_on
            & ~mask_i.tristate_reset_mask;
        // per lane mux between live data and the initial value
        for (int i = 0; i < NUM_LANES; i++) begin
            next_state.tx_pad[i] = next_state.lane_rst[i] ?
                tx_init_i[i] : tx_data_i[i];
        end
        next_state.tri_pad = next_state.tri_rst ?
            tx_init_tri_i : tri_data_i;
        // sticky flag: writes during lane reset corrupt the slice
        // state, so the controller can see it broke the ordering
        if (reg_req_i.wr_en && ctrl_hit
            && !reg_req_i.wr_data[NSR_LANE_RST_BIT]) begin
            next_state.wren_violation = 1'b0;
        end
        if (lane_rst_on && phy_write_enable_i) begin
            next_state.wren_violation = 1'b1;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state <= '0;
            state.ctrl <= NSR_SLICE_RESET_CONTROL_RST[NSR_CTRL_FIELD_W-1:0];
        end else begin
            state <= next_state;
        end
    end

    // ************************************************************
    // strobe gate
    // ************************************************************
    nsr_strobe_gate u_gate (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .clr_gate_bit_i(state.ctrl[NSR_CLR_GATE_BIT]),
        .gate_set_i(strobe_gate_set_i),
        .gate_o(strobe_gate_o)
    );

    // hold length is timed by the controller in pll cycles; this
    // block just follows the bit level for as long as it stands
    assign lane_slice_soft_reset_o = state.lane_rst;
    assign tristate_slice_soft_reset_o = state.tri_rst;
    assign tx_pad_o = state.tx_pad;
    assign tri_pad_o = state.tri_pad;
    assign reg_rd_data_o = state.rd_data;
    assign wren_violation_o = state.wren_violation;

    // ************************************************************
    // checks
    // ************************************************************
    // an attempt started on the edge that releases reset would see
    // history from before the reset, so every antecedent except the
    // one of p_write_to_reset waits for reset to be sampled low first
    property p_ctrl_write;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (!sys_rst_i && reg_req_i.wr_en && ctrl_hit) |=>
            state.ctrl == $past(reg_req_i.wr_data[2:0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("control write not stored");

    property p_lane_reset;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        !sys_rst_i |=> lane_slice_soft_reset_o ==
            ({NUM_LANES{$past(lane_rst_on)}}
            & ~$past(mask_i.lane_reset_mask));
    endproperty
    a_lane_reset: assert property (p_lane_reset)
        else $error("lane reset does not follow bit and mask");

    property p_write_to_reset;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (reg_req_i.wr_en && ctrl_hit && reg_req_i.wr_data[1]
            && mask_i.lane_reset_mask == '0) ##1
            (!reg_req_i.wr_en && mask_i.lane_reset_mask == '0)
            |=> lane_slice_soft_reset_o == {NUM_LANES{1'b1}};
    endproperty
    a_write_to_reset: assert property (p_write_to_reset)
        else $error("lane reset not raised two cycles after write");

    property p_pad_init;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        !sys_rst_i |=> tx_pad_o == ((lane_slice_soft_reset_o
            & $past(tx_init_i))
            | (~lane_slice_soft_reset_o & $past(tx_data_i)));
    endproperty
    a_pad_init: assert property (p_pad_init)
        else $error("pad value wrong for reset state");

    property p_tri_init;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (!sys_rst_i && tri_rst_on && !mask_i.tristate_reset_mask) |=>
            tristate_slice_soft_reset_o
            && tri_pad_o == $past(tx_init_tri_i);
    endproperty
    a_tri_init: assert property (p_tri_init)
        else $error("tristate slice not forced to initial value");

    property p_tri_masked;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (!sys_rst_i && mask_i.tristate_reset_mask) |=>
            !tristate_slice_soft_reset_o
            && tri_pad_o == $past(tri_data_i);
    endproperty
    a_tri_masked: assert property (p_tri_masked)
        else $error("masked tristate slice was reset");

    property p_read_back;
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (!sys_rst_i && ctrl_hit) |=> reg_rd_data_o[15:3] == 13'h0000
            && reg_rd_data_o[2:0] == $past(state.ctrl);
    endproperty
    a_read_back: assert property (p_read_back)
        else $error("read back of control register wrong");

    c_lane_reset_seen: cover property (@(posedge core_clk_i)
        disable iff (sys_rst_i) $rose(lane_slice_soft_reset_o[0]));
    c_tri_reset_seen: cover property (@(posedge core_clk_i)
        disable iff (sys_rst_i) $rose(tristate_slice_soft_reset_o));
    c_partial_mask: cover property (@(posedge core_clk_i)
        disable iff (sys_rst_i) lane_slice_soft_reset_o[0]
        && !lane_slice_soft_reset_o[1]);

endmodule : nsr_slice_reset_ctrl

// ### tb/nsr_ctrl_model.sv
`timescale 1ns/1ps
// ****************************************************************
// controller model driving the register port and write enable
// ****************************************************************
module nsr_ctrl_model
    import nsr_pkg::*;
#(
    // pll cycles per control cycle; 1 over-holds, the safe default
    parameter int PLL_PER_CTRL = 1
) (
    input wire logic core_clk_i,
    output nsr_reg_req_t reg_req_o,
    output logic phy_write_enable_o
);
    localparam int HOLD_CYCLES = NSR_HOLD_CTRL_CYCLES +
        (NSR_HOLD_PLL_W8 + PLL_PER_CTRL - 1) / PLL_PER_CTRL;

    // idle: no register write, write enable high, address at zero until the first access
    initial begin
        reg_req_o = '0;
        phy_write_enable_o = 1'b1;
    end

    // one write strobe, then the address stays for reading
    task automatic write_reg(input logic [7:0] addr,
                             input logic [15:0] data);
        @(posedge core_clk_i);
        reg_req_o <= '{addr: addr, wr_en: 1'b1, wr_data: data};
        @(posedge core_clk_i);
        reg_req_o.wr_en <= 1'b0;
    endtask : write_reg

    // read data is registered, so wait past the sampling edge
    task automatic read_addr(input logic [7:0] addr);
        @(posedge core_clk_i);
        reg_req_o.addr <= addr;
        repeat (2) @(posedge core_clk_i);
        #1;
    endtask : read_addr

    task automatic set_wren(input logic value);
        @(posedge core_clk_i);
        phy_write_enable_o <= value;
    endtask : set_wren

    // assert resets, dropping write enable first for a lane reset
    task automatic hold_reset(input logic [15:0] data);
        if (data[NSR_LANE_RST_BIT]) begin
            set_wren(1'b0);
        end
        write_reg(NSR_SLICE_RESET_CONTROL_ADDR, data);
        repeat (HOLD_CYCLES) @(posedge core_clk_i);
        #1;
    endtask : hold_reset
endmodule : nsr_ctrl_model

// ### tb/nsr_slice_reset_ctrl_bench.sv
`timescale 1ns/1ps
module nsr_slice_reset_ctrl_bench
    import nsr_pkg::*;
;
    logic core_clk;
    logic sys_rst;
    nsr_reg_req_t reg_req;
    nsr_mask_t mask;
    logic wren;
    logic [5:0] tx_data, tx_init, lane_rst, tx_pad;
    logic tri_data, tx_init_tri, gate_set;
    logic [15:0] rd_data;
    logic tri_rst, tri_pad, gate, viol;
    int errors = 0;
    int num_checks = 0;

    nsr_ctrl_model ctrl_u (.core_clk_i(core_clk), .reg_req_o(reg_req),
        .phy_write_enable_o(wren));

    nsr_slice_reset_ctrl #(.NUM_LANES(6)) dut_u (
        .core_clk_i(core_clk), .sys_rst_i(sys_rst), .reg_req_i(reg_req),
        .mask_i(mask), .phy_write_enable_i(wren), .tx_data_i(tx_data),
        .tx_init_i(tx_init), .tri_data_i(tri_data),
        .tx_init_tri_i(tx_init_tri), .strobe_gate_set_i(gate_set),
        .reg_rd_data_o(rd_data), .lane_slice_soft_reset_o(lane_rst),
        .tristate_slice_soft_reset_o(tri_rst), .tx_pad_o(tx_pad),
        .tri_pad_o(tri_pad), .strobe_gate_o(gate),
        .wren_violation_o(viol));

    // ************************************************************
    // clock, reporting
    // ************************************************************
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic check(input string name, input logic [15:0] exp,
                         input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic results();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    task automatic settle();
        repeat (3) @(posedge core_clk);
        #1;
    endtask : settle

    // a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        results();
    end

    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        sys_rst = 1'b1;
        mask = '{tristate_reset_mask: 1'b0, lane_reset_mask: 6'h03};
        tx_data = 6'h2a;
        tx_init = 6'h15;
        tri_data = 1'b1;
        tx_init_tri = 1'b0;
        gate_set = 1'b0;
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        ctrl_u.read_addr(NSR_SLICE_RESET_CONTROL_ADDR);
        check("ctrl_reset", NSR_SLICE_RESET_CONTROL_RST, rd_data);
        check("lane_rst_idle", 16'h0000, 16'(lane_rst));
        // lane reset: masked lanes pass data, the rest show init
        ctrl_u.hold_reset(16'h0002);
        // invert at lane width first, then widen with zeros
        check("lane_rst", {10'h000, ~mask.lane_reset_mask},
            16'(lane_rst));
        check("tx_pad", 16'((mask.lane_reset_mask & tx_data) |
            (~mask.lane_reset_mask & tx_init)), 16'(tx_pad));
        check("tri_rst_off", 16'h0000, 16'(tri_rst));
        check("viol_low", 16'h0000, 16'(viol));
        ctrl_u.read_addr(NSR_SLICE_RESET_CONTROL_ADDR);
        check("ctrl_rd", 16'h0002, rd_data);
        // write enable raised inside the reset is flagged
        ctrl_u.set_wren(1'b1);
        settle();
        check("viol_set", 16'h0001, 16'(viol));
        ctrl_u.set_wren(1'b0);
        ctrl_u.write_reg(NSR_SLICE_RESET_CONTROL_ADDR, 16'h0000);
        settle();
        check("viol_clr", 16'h0000, 16'(viol));
        check("lane_rst_rel", 16'h0000, 16'(lane_rst));
        check("tx_pad_live", 16'(tx_data), 16'(tx_pad));
        // tristate reset, reserved bits dropped
        ctrl_u.hold_reset(16'hfffc);
        check("tri_rst", 16'h0001, 16'(tri_rst));
        check("tri_pad", 16'(tx_init_tri), 16'(tri_pad));
        check("lane_rst_tri", 16'h0000, 16'(lane_rst));
        ctrl_u.read_addr(NSR_SLICE_RESET_CONTROL_ADDR);
        check("ctrl_rsvd", 16'h0004, rd_data);
        @(posedge core_clk);
        mask.tristate_reset_mask <= 1'b1;
        settle();
        check("tri_masked", 16'h0000, 16'(tri_rst));
        check("tri_pad_live", 16'(tri_data), 16'(tri_pad));
        ctrl_u.write_reg(NSR_SLICE_RESET_CONTROL_ADDR, 16'h0000);
        // unmapped address: write ignored, reads zero
        ctrl_u.write_reg(8'h04, 16'h0002);
        settle();
        check("unmapped_wr", 16'h0000, 16'(lane_rst));
        ctrl_u.read_addr(8'h04);
        check("unmapped_rd", NSR_UNMAPPED_READ, rd_data);
        // strobe gate: toggles clear, a steady level does not
        @(posedge core_clk);
        gate_set <= 1'b1;
        @(posedge core_clk);
        gate_set <= 1'b0;
        settle();
        check("gate_set", 16'h0001, 16'(gate));
        ctrl_u.write_reg(NSR_SLICE_RESET_CONTROL_ADDR, 16'h0001);
        settle();
        check("gate_clr_rise", 16'h0000, 16'(gate));
        @(posedge core_clk);
        gate_set <= 1'b1;
        @(posedge core_clk);
        gate_set <= 1'b0;
        ctrl_u.write_reg(NSR_SLICE_RESET_CONTROL_ADDR, 16'h0001);
        settle();
        check("gate_level", 16'h0001, 16'(gate));
        ctrl_u.write_reg(NSR_SLICE_RESET_CONTROL_ADDR, 16'h0000);
        settle();
        check("gate_clr_fall", 16'h0000, 16'(gate));
        // all lanes unmasked; pads follow init while it changes
        @(posedge core_clk);
        mask.lane_reset_mask <= 6'h00;
        tx_init <= 6'h2d;
        ctrl_u.hold_reset(16'h0002);
        check("lane_rst_all", 16'h003f, 16'(lane_rst));
        check("tx_pad_all", 16'h002d, 16'(tx_pad));
        @(posedge core_clk);
        tx_init <= 6'h12;
        tx_data <= 6'h33;
        tx_init_tri <= 1'b1;
        mask.tristate_reset_mask <= 1'b0;
        ctrl_u.hold_reset(16'h0006);
        check("tx_pad_new", 16'h0012, 16'(tx_pad));
        check("tri_pad_one", 16'h0001, 16'(tri_pad));
        check("viol_quiet", 16'h0000, 16'(viol));
        // reset in mid run drops every slice reset and the stored bits
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        ctrl_u.read_addr(NSR_SLICE_RESET_CONTROL_ADDR);
        check("ctrl_rst2", NSR_SLICE_RESET_CONTROL_RST, rd_data);
        check("lane_rst2", 16'h0000, 16'(lane_rst));
        check("tx_pad2", 16'h0033, 16'(tx_pad));
        check("tri_rst2", 16'h0000, 16'(tri_rst));
        results();
    end
endmodule : nsr_slice_reset_ctrl_bench
